// ---- hw/flash_cmd_regs.vh ----
// flash_cmd_regs.vh: opcodes, field positions, header bytes and timing
// assumes: included by bare name from the design files
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
`define OP_FAST_READ 8'h0B
`define OP_WRAP_READ 8'h0C
`define OP_SET_PARAM 8'hC0
`define OP_QUAD_ON 8'h38
`define OP_QUAD_OFF 8'hFF
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_PARAM_RD 8'h5A
`define DUMMY_HI 5
`define DUMMY_LO 4
`define WRAP_HI 1
`define WRAP_LO 0
`define PARAM_RESET 8'h00
`define PARAM_DUMMY 4'h8
`define HDR_LAST 8'h17
`define HDR_FILL 8'hFF
`define RESET_TIME_NS 60000
`define CLK_PERIOD_NS 10
`endif

// ---- hw/pin_sync.v ----
// pin_sync.v: three-stage synchroniser with agreement filter
// assumes: d is asynchronous to clk; rstN is already synchronous
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire rstN,
    // pins in, clean level out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q <= s3_r;
            end
        end
    end
endmodule // pin_sync

// ---- hw/flash_cmd_core.v ----
// flash_cmd_core.v: command slice of a serial flash: wrap read in quad
// command mode, quad mode entry and exit, two-frame reset, parameter header.
// assumes: host drives csN, sck, io; sck far slower than clk.
`timescale 1ns/1ps
`include "flash_cmd_regs.vh"
module flash_cmd_core #(
    parameter RESET_CYCLES = (`RESET_TIME_NS + `CLK_PERIOD_NS - 1)
        / `CLK_PERIOD_NS,
    parameter [7:0] MAKER_ID = 8'h5E // arbitrary value
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial link pins
    input wire csN,
    input wire sck,
    input wire [3:0] ioIn,
    output reg [3:0] ioOut,
    output reg [3:0] ioOe,
    // loose status and control bits
    input wire quadEnableBit,
    input wire setWriteEnable,
    input wire setSuspend,
    input wire [2:0] wrapSettingIn,
    input wire wrapSettingLoad,
    output reg quadCommandMode,
    output reg writeEnableLatch,
    output reg suspendFlag,
    output reg [7:0] readParameterBits,
    output reg [7:0] continuousReadModeBits,
    output reg [2:0] wrapSettingBits,
    output reg resetBusy,
    // array read port
    output reg [23:0] arrayAddr,
    output reg arrayReq,
    input wire [7:0] arrayData
);
    localparam S_OP = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_DUMMY = 3'h2;
    localparam S_DATA = 3'h3;
    localparam S_IDLE = 3'h4;
    localparam [15:0] RST_CNT = RESET_CYCLES;

    reg rs1_r;
    reg rstN;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rstN <= rs1_r;
        end
    end

    wire [5:0] pins;
    pin_sync #(.W(6)) u_sync (
        .clk(clk),
        .rstN(rstN),
        .d({csN, sck, ioIn}),
        .q(pins)
    );
    wire csS = pins[5];
    wire sckS = pins[4];
    wire [3:0] ioS = pins[3:0];
    reg sckD_r;
    reg csD_r;
    wire rise = sckS & ~sckD_r & ~csS;
    wire fall = ~sckS & sckD_r & ~csS;
    wire frameEnd = csS & ~csD_r;

    reg [2:0] state_r;
    reg [7:0] shift_r;
    reg [5:0] bitCnt_r;
    reg [7:0] op_r;
    reg [7:0] lastOp_r;
    reg enArmed_r;
    reg [15:0] rstCnt_r;
    reg [7:0] outByte_r;
    reg [23:0] addr_r;
    reg [3:0] dummies_r;
    reg [6:0] wrapMask_r;

    // ----------------------------------------
    // parameter decode
    // ----------------------------------------
    reg [3:0] pDummy;
    reg [6:0] pMask;
    always @* begin
        case (readParameterBits[`DUMMY_HI:`DUMMY_LO])
            2'b00: pDummy = 4'h4;
            2'b01: pDummy = 4'h6;
            default: pDummy = 4'h8;
        endcase
        case (readParameterBits[`WRAP_HI:`WRAP_LO])
            2'b00: pMask = 7'h07;
            2'b01: pMask = 7'h0F;
            2'b10: pMask = 7'h1F;
            default: pMask = 7'h3F;
        endcase
    end

    // ----------------------------------------
    // header space contents
    // ----------------------------------------
    reg [7:0] hdrByte;
    always @* begin
        hdrByte = `HDR_FILL;
        case (addr_r[7:0])
            8'h00: hdrByte = 8'h53;
            8'h01: hdrByte = 8'h46;
            8'h02: hdrByte = 8'h44;
            8'h03: hdrByte = 8'h50;
            8'h04: hdrByte = 8'h00;
            8'h05: hdrByte = 8'h01;
            8'h06: hdrByte = 8'h01;
            8'h08: hdrByte = 8'h00;
            8'h09: hdrByte = 8'h00;
            8'h0A: hdrByte = 8'h01;
            8'h0B: hdrByte = 8'h09;
            8'h0C: hdrByte = 8'h30;
            8'h0D: hdrByte = 8'h00;
            8'h0E: hdrByte = 8'h00;
            8'h10: hdrByte = MAKER_ID;
            8'h11: hdrByte = 8'h00;
            8'h12: hdrByte = 8'h01;
            8'h13: hdrByte = 8'h03;
            8'h14: hdrByte = 8'h60;
            8'h15: hdrByte = 8'h00;
            8'h16: hdrByte = 8'h00;
            default: hdrByte = `HDR_FILL;
        endcase
        if (addr_r[23:8] != 16'h0000) begin
            hdrByte = `HDR_FILL;
        end
    end

    wire isHdr = (op_r == `OP_PARAM_RD);
    wire [7:0] nextByte = isHdr ? hdrByte : arrayData;
    wire [3:0] lanes = quadCommandMode ? 4'h4 : 4'h1;
    wire [7:0] shIn = quadCommandMode ? {shift_r[3:0], ioS} :
        {shift_r[6:0], ioS[0]};
    wire [5:0] opBits = 6'h08;
    // plain reads run on past the window; only the wrap read folds back
    wire [23:0] addrInc = addr_r + 24'h000001;
    wire [23:0] addrWrap = {addr_r[23:7],
        (addr_r[6:0] & ~wrapMask_r) | (addrInc[6:0] & wrapMask_r)};

    // ----------------------------------------
    // frame decoder
    // ----------------------------------------
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            sckD_r <= 1'b0;
            csD_r <= 1'b1;
            state_r <= S_OP;
            shift_r <= 8'h00;
            bitCnt_r <= 6'h00;
            op_r <= 8'h00;
            lastOp_r <= 8'h00;
            enArmed_r <= 1'b0;
            rstCnt_r <= 16'h0000;
            outByte_r <= 8'h00;
            addr_r <= 24'h000000;
            dummies_r <= 4'h0;
            wrapMask_r <= 7'h00;
            quadCommandMode <= 1'b0;
            writeEnableLatch <= 1'b0;
            suspendFlag <= 1'b0;
            readParameterBits <= `PARAM_RESET;
            continuousReadModeBits <= 8'h00;
            wrapSettingBits <= 3'h0;
            resetBusy <= 1'b0;
            ioOut <= 4'h0;
            ioOe <= 4'h0;
            arrayAddr <= 24'h000000;
            arrayReq <= 1'b0;
        end else begin
            sckD_r <= sckS;
            csD_r <= csS;
            arrayReq <= 1'b0;
            if (setWriteEnable) begin
                writeEnableLatch <= 1'b1;
            end
            if (setSuspend) begin
                suspendFlag <= 1'b1;
            end
            if (wrapSettingLoad) begin
                wrapSettingBits <= wrapSettingIn;
            end
            if (resetBusy) begin
                // reset interval: frames are ignored
                rstCnt_r <= rstCnt_r - 16'h0001;
                if (rstCnt_r == 16'h0001) begin
                    resetBusy <= 1'b0;
                end
                state_r <= S_OP;
                ioOe <= 4'h0;
            end else if (csS) begin
                ioOe <= 4'h0;
                state_r <= S_OP;
                bitCnt_r <= 6'h00;
                if (frameEnd) begin
                    // reset enable only arms the next frame
                    enArmed_r <= (lastOp_r == `OP_RST_EN);
                    if (lastOp_r == `OP_RST && enArmed_r) begin
                        // power-on defaults
                        quadCommandMode <= 1'b0;
                        writeEnableLatch <= 1'b0;
                        suspendFlag <= 1'b0;
                        readParameterBits <= `PARAM_RESET;
                        continuousReadModeBits <= 8'h00;
                        wrapSettingBits <= 3'h0;
                        resetBusy <= 1'b1;
                        rstCnt_r <= RST_CNT;
                    end
                    lastOp_r <= 8'h00;
                end
            end else if (rise) begin
                shift_r <= shIn;
                bitCnt_r <= bitCnt_r + {2'b00, lanes};
                case (state_r)
                    S_OP: begin
                        if (bitCnt_r + {2'b00, lanes} == opBits) begin
                            op_r <= shIn;
                            lastOp_r <= shIn;
                            bitCnt_r <= 6'h00;
                            state_r <= S_IDLE;
                            // mode switch touches nothing else
                            if (shIn == `OP_QUAD_ON && quadEnableBit) begin
                                quadCommandMode <= 1'b1;
                            end
                            if (shIn == `OP_QUAD_OFF && quadCommandMode) begin
                                quadCommandMode <= 1'b0;
                            end
                            if (shIn == `OP_PARAM_RD ||
                                shIn == `OP_FAST_READ ||
                                shIn == `OP_SET_PARAM ||
                                (shIn == `OP_WRAP_READ && quadCommandMode)) begin
                                state_r <= S_ADDR;
                            end
                            // window and dummies fixed per frame
                            wrapMask_r <= (shIn == `OP_WRAP_READ) ?
                                pMask : 7'h7F;
                            dummies_r <= (shIn == `OP_PARAM_RD) ?
                                `PARAM_DUMMY : pDummy;
                        end
                    end
                    S_ADDR: begin
                        if (op_r == `OP_SET_PARAM) begin
                            if (bitCnt_r + {2'b00, lanes} == opBits) begin
                                readParameterBits <= shIn;
                                state_r <= S_IDLE;
                            end
                        end else begin
                            addr_r <= quadCommandMode ?
                                {addr_r[19:0], ioS} : {addr_r[22:0], ioS[0]};
                            if (bitCnt_r + {2'b00, lanes} == 6'd24) begin
                                bitCnt_r <= 6'h00;
                                state_r <= S_DUMMY;
                            end
                        end
                    end
                    S_DUMMY: begin
                        arrayAddr <= addr_r;
                        arrayReq <= 1'b1;
                        if (bitCnt_r[3:0] + 4'h1 == dummies_r) begin
                            bitCnt_r <= 6'h00;
                            state_r <= S_DATA;
                        end else begin
                            bitCnt_r <= bitCnt_r + 6'h01;
                        end
                    end
                    S_DATA: begin
                        bitCnt_r <= bitCnt_r;
                    end
                    default: begin
                        bitCnt_r <= bitCnt_r;
                    end
                endcase
            end else if (fall && state_r == S_DATA) begin
                // shift data out on the falling edge
                if (bitCnt_r == 6'h00) begin
                    outByte_r <= quadCommandMode ? {nextByte[3:0], 4'h0} :
                        {nextByte[6:0], 1'b0};
                    ioOut <= quadCommandMode ? nextByte[7:4] :
                        {2'b00, nextByte[7], 1'b0};
                    // wrap inside the aligned window; increment
                    addr_r <= (op_r == `OP_WRAP_READ) ? addrWrap : addrInc;
                    bitCnt_r <= quadCommandMode ? 6'h04 : 6'h01;
                end else begin
                    outByte_r <= quadCommandMode ? {outByte_r[3:0], 4'h0} :
                        {outByte_r[6:0], 1'b0};
                    ioOut <= quadCommandMode ? outByte_r[7:4] :
                        {2'b00, outByte_r[7], 1'b0};
                    bitCnt_r <= (bitCnt_r + {2'b00, lanes} == opBits) ?
                        6'h00 : bitCnt_r + {2'b00, lanes};
                end
                ioOe <= quadCommandMode ? 4'hF : 4'h2;
            end else if (rise == 1'b0 && state_r == S_DATA && bitCnt_r == 6'h00) begin
                arrayAddr <= addr_r;
            end
        end
    end
endmodule // flash_cmd_core

// ---- test/flash_cmd_core_assertions.sv ----
// flash_cmd_core_assertions.sv: port-level timing checks for the core
// assumes: bound to flash_cmd_core, single clock domain on clk
`timescale 1ns/1ps
module flash_cmd_core_assertions #(
    parameter int RESET_CYCLES = 6000
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // link and status ports
    input wire csN,
    input wire [3:0] ioOe,
    input wire quadEnableBit,
    input wire quadCommandMode,
    input wire writeEnableLatch,
    input wire suspendFlag,
    input wire [7:0] readParameterBits,
    input wire [7:0] continuousReadModeBits,
    input wire [2:0] wrapSettingBits,
    input wire resetBusy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // reset interval length, mode switch and pin drive checks
    // ------------------------------------------------------------
    int busyCnt;
    always @(posedge clk or negedge rst_n)
        if (!rst_n) busyCnt <= 0;
        else busyCnt <= resetBusy ? busyCnt + 1 : 0;
    sequence csIdle; csN [*8]; endsequence
    sequence busyEnd; $fell(resetBusy); endsequence
    sequence modeFlip;
        $changed(quadCommandMode) && !resetBusy && !$past(resetBusy);
    endsequence
    a_quad_needs_qe: assert property (
        $rose(quadCommandMode) |-> quadEnableBit)
        else $error("quad mode entered with enable clear");
    a_busy_max: assert property (
        resetBusy |-> busyCnt <= RESET_CYCLES)
        else $error("reset interval too long");
    a_busy_min: assert property (
        busyEnd |-> busyCnt >= RESET_CYCLES - 1)
        else $error("reset interval too short");
    a_reset_clears: assert property (
        busyEnd |-> !writeEnableLatch && !suspendFlag && !quadCommandMode
        && readParameterBits == 8'h00 && continuousReadModeBits == 8'h00
        && wrapSettingBits == 3'h0)
        else $error("state not cleared by reset");
    a_busy_frozen: assert property (
        resetBusy && $past(resetBusy) |->
        $stable(quadCommandMode) && $stable(readParameterBits))
        else $error("command taken during reset interval");
    a_mode_keeps: assert property (
        modeFlip |-> $stable(writeEnableLatch) && $stable(suspendFlag)
        && $stable(wrapSettingBits))
        else $error("mode switch disturbed latch state");
    a_spi_one_line: assert property (
        !quadCommandMode |-> ioOe[3:2] == 2'h0 && !ioOe[0])
        else $error("extra lines driven in single-line mode");
    a_oe_idle: assert property (
        csIdle |-> ioOe == 4'h0)
        else $error("pins driven while deselected");
    a_param_quad: assert property (
        $changed(readParameterBits) && !resetBusy && !$past(resetBusy)
        |-> quadCommandMode)
        else $error("read parameters changed outside quad mode");
endmodule // flash_cmd_core_assertions

bind flash_cmd_core flash_cmd_core_assertions #(
    .RESET_CYCLES(RESET_CYCLES)
) u_chk (.clk, .rst_n, .csN, .ioOe, .quadEnableBit, .quadCommandMode,
    .writeEnableLatch, .suspendFlag, .readParameterBits,
    .continuousReadModeBits, .wrapSettingBits, .resetBusy);

// ---- test/host_model.sv ----
// host_model.sv: behavioural serial host driving the flash link pins
// assumes: clk is the 100 MHz bench clock; link clock period is 80 ns
`timescale 1ns/1ps
module host_model (
    // bench clock
    input wire logic clk,
    // device side of the pins
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe,
    // pins toward the device
    output logic csN,
    output logic sck,
    output wire logic [3:0] ioIn
);
    logic [3:0] drv;
    // wire level: device wins where it drives
    assign ioIn = (ioOe & ioOut) | (~ioOe & drv);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        drv = 4'hA;
    end
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // one link clock, sampled just before the fall
    task automatic tick(input logic [3:0] v, output logic [3:0] o);
        drv <= v;
        half();
        sck <= 1'b1;
        half();
        o = ioOut;
        sck <= 1'b0;
    endtask
    task automatic xfer(input bit q, input logic [7:0] tx,
        output logic [7:0] rx);
        logic [3:0] o;
        for (int i = 0; i < (q ? 2 : 8); i++) begin
            tick(q ? tx[7 - 4 * i -: 4] : {drv[3:1], tx[7 - i]}, o);
            rx = q ? {rx[3:0], o} : {rx[6:0], o[1]};
        end
    endtask
    task automatic dummy(int n);
        logic [3:0] o;
        repeat (n) tick(4'h0, o);
    endtask
    task automatic open();
        @(posedge clk);
        csN <= 1'b0;
        half();
    endtask
    // released lines must not keep showing the last value
    task automatic close();
        half();
        csN <= 1'b1;
        drv <= ~drv;
        repeat (8) @(posedge clk);
    endtask
endmodule // host_model

// ---- test/tb.sv ----
// tb.sv: self-checking bench for the flash command core
// assumes: host_model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, csN, sck, quadEnableBit, setWriteEnable, setSuspend;
    logic wrapSettingLoad, quadCommandMode, writeEnableLatch, suspendFlag;
    logic resetBusy, arrayReq;
    logic [3:0] ioIn, ioOut, ioOe;
    logic [2:0] wrapSettingIn, wrapSettingBits;
    logic [7:0] readParameterBits, continuousReadModeBits, arrayData, rx;
    logic [23:0] arrayAddr;
    int fails, comparisons;
    localparam int RST_CYC = 300;
    localparam logic [7:0] MAKER = 8'h3A; // arbitrary value
    logic [7:0] hdr [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01,
        8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00,
        8'hFF, MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
    assign arrayData = arrayAddr[7:0] ^ 8'h5A;
    flash_cmd_core #(.RESET_CYCLES(RST_CYC), .MAKER_ID(MAKER))
        u_flash_cmd_core (.clk, .rst_n, .csN, .sck, .ioIn, .ioOut, .ioOe,
        .quadEnableBit, .setWriteEnable, .setSuspend, .wrapSettingIn,
        .wrapSettingLoad, .quadCommandMode, .writeEnableLatch,
        .suspendFlag, .readParameterBits, .continuousReadModeBits,
        .wrapSettingBits, .resetBusy, .arrayAddr, .arrayReq, .arrayData);
    host_model u_host_model (.clk, .ioOut, .ioOe, .csN, .sck, .ioIn);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one opcode per frame
    task automatic cmd(bit q, logic [7:0] op);
        u_host_model.open();
        u_host_model.xfer(q, op, rx);
        u_host_model.close();
    endtask
    task automatic head(bit q, logic [7:0] op, logic [23:0] a);
        u_host_model.open();
        u_host_model.xfer(q, op, rx);
        for (int i = 2; i >= 0; i--) u_host_model.xfer(q, a[8*i +: 8], rx);
    endtask
    task automatic test_sfdp();
        head(0, 8'h5A, 24'h0);
        u_host_model.dummy(8);
        for (int i = 0; i < 32; i++) begin
            u_host_model.xfer(0, 8'hFF, rx);
            check("header", rx, i < 24 ? hdr[i] : 8'hFF);
        end
        u_host_model.close();
    endtask
    task automatic test_quad();
        cmd(0, 8'h38);
        check("quad off", quadCommandMode, 0);
        @(posedge clk);
        {setWriteEnable, setSuspend, wrapSettingLoad} <= 3'h7;
        wrapSettingIn <= 3'h5;
        quadEnableBit <= 1'b1;
        @(posedge clk);
        {setWriteEnable, setSuspend, wrapSettingLoad} <= 3'h0;
        cmd(0, 8'h38);
        check("quad on", quadCommandMode, 1);
        check("kept", {writeEnableLatch, suspendFlag, wrapSettingBits},
            5'h1D);
    endtask
    task automatic test_wrap();
        logic [7:0] p;
        int w;
        for (int k = 0; k < 4; k++) begin
            p = 8'h11 * k;
            w = 8 << k;
            u_host_model.open();
            u_host_model.xfer(1, 8'hC0, rx);
            u_host_model.xfer(1, p, rx);
            u_host_model.close();
            check("params", readParameterBits, p);
            head(1, 8'h0C, 24'h140 + w - 2);
            u_host_model.dummy(k == 0 ? 4 : k == 1 ? 6 : 8);
            for (int j = 0; j < 4; j++) begin
                u_host_model.xfer(1, 8'hFF, rx);
                check("wrap", rx, (8'h40 + (w - 2 + j) % w) ^ 8'h5A);
            end
            u_host_model.close();
        end
    endtask
    task automatic test_exit();
        cmd(1, 8'hFF);
        check("exit", quadCommandMode, 0);
        check("kept", {writeEnableLatch, wrapSettingBits}, 4'hD);
        // plain fast read crosses the 128-byte line without folding back
        head(0, 8'h0B, 24'h00017F);
        u_host_model.dummy(8);
        for (int j = 0; j < 2; j++) begin
            u_host_model.xfer(0, 8'hFF, rx);
            check("fast", rx, (8'h7F + j) ^ 8'h5A);
        end
        u_host_model.close();
        cmd(0, 8'h38);
    endtask
    task automatic test_reset();
        check("idle first", resetBusy, 0);
        cmd(1, 8'h99);
        check("lone", {resetBusy, writeEnableLatch}, 2'b01);
        cmd(1, 8'h66);
        cmd(1, 8'h99);
        check("busy", resetBusy, 1);
        cmd(0, 8'h38);
        for (int i = 0; i < 2 * RST_CYC && resetBusy; i++) @(posedge clk);
        check("busy end", resetBusy, 0);
        check("defaults", {quadCommandMode, writeEnableLatch, suspendFlag,
            wrapSettingBits, readParameterBits, continuousReadModeBits},
            0);
    endtask
    initial begin
        rst_n = 1'b0;
        quadEnableBit = 1'b0;
        {setWriteEnable, setSuspend, wrapSettingLoad} = 3'h0;
        wrapSettingIn = 3'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        test_sfdp();
        test_quad();
        test_wrap();
        test_exit();
        test_reset();
        stop_test();
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule // tb
